// *** core/lvds_pixel_readout_serializer.sv ***
// pixel read-out sequencer and lane serializer with forwarded ddr clock
//
// Functional notes
// - each pixel sent lsb first, bit0 clock high
// - 10-bit mode: bit is tenth of pixel
// - 12-bit mode: bit is twelfth of pixel
// - lanes send bursts of 128 pixels
// - one master clock period per pixel
// - one-pixel overhead gap between bursts
// - default 10-bit: 16 lanes, one burst/row
// - 8 lanes: two bursts, two gaps per row
// - 4 lanes 10-bit: four bursts, four gaps
// - 2 lanes 10-bit: eight bursts, eight gaps
// - 12-bit mode defaults to 4 lanes
// - 2 lanes 12-bit: eight bursts, eight gaps
// - rows per frame programmable, default 2048
// - 8 lanes: even lanes idle, may power down
// - 4 lanes: only lanes 1,5,9,13 carry data
// - 2 lanes: only lanes 1 and 9 used
// - forwarded clock ddr, half bit rate, synchronous
// - control lane words marks validity, same width
`default_nettype none
module lvds_pixel_readout_serializer
	import lprs_pkg::*;
#(
	parameter int FIFO_DEPTH = LPRS_FIFO_DEPTH
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic serialClock,
	input wire logic frameRequest,
	input wire logic [1:0] laneSelect,
	input wire logic twelveBitMode,
	input wire logic [15:0] rowsPerFrame,
	input wire logic [15:0] laneDisable,
	input wire lprs_word_t [LPRS_LANES-1:0] pixelWords,
	output logic [6:0] pixelIndex,
	output logic [2:0] burstIndex,
	output logic [15:0] rowIndex,
	output logic readoutBusy,
	output logic slotStall,
	output logic [15:0] lanePowerDown,
	output logic [15:0] dataLanes,
	output logic controlLane,
	output logic lvdsForwardedClock
);
	localparam int AW = $clog2(FIFO_DEPTH);

	// ---------------- master clock domain ----------------
	logic reqMeta_reg, reqSync_reg, reqLast_reg;
	lprs_state_t state_reg, state_next;
	logic [6:0] pixCnt_reg, pixCnt_next;
	logic [2:0] burstCnt_reg, burstCnt_next;
	logic [15:0] rowCnt_reg, rowCnt_next;
	logic [3:0] stride_reg, stride_next;
	logic wide_reg, wide_next;
	logic [15:0] rowLimit_reg, rowLimit_next;
	logic [15:0] laneOff_reg;
	logic full_reg;
	logic busy_reg;
	logic [AW:0] wBin_reg, wGray_reg, rGray_reg, rGrayMeta_reg, rGraySync_reg;
	lprs_slot_t fifoMem [FIFO_DEPTH];

	wire frameRise = reqSync_reg & ~reqLast_reg;
	wire wrEn = ~full_reg;
	wire burstEnd = pixCnt_reg == LPRS_BURST_LAST;
	wire rowEnd = burstCnt_reg == 3'(stride_reg - 4'h1);
	wire frameEnd = rowCnt_reg == rowLimit_reg - 16'h0001;
	wire [AW:0] wBinNext = wBin_reg + (AW+1)'(wrEn);
	wire [AW:0] wGrayNext = wBinNext ^ (wBinNext >> 1);
	wire fullNext = wGrayNext == {~rGraySync_reg[AW:AW-1], rGraySync_reg[AW-2:0]};

	// lane count and rows per frame taken at the start of a frame
	wire [3:0] strideSel10 = laneSelect == LPRS_SEL_16 ? LPRS_STRIDE_16 :
		laneSelect == LPRS_SEL_8 ? LPRS_STRIDE_8 :
		laneSelect == LPRS_SEL_4 ? LPRS_STRIDE_4 : LPRS_STRIDE_2;
	wire [3:0] strideSel12 = laneSelect == LPRS_SEL_2 ? LPRS_STRIDE_2 : LPRS_STRIDE_4;
	wire [3:0] strideSel = twelveBitMode ? strideSel12 : strideSel10;
	wire [15:0] rowSel = rowsPerFrame == 16'h0000 ? LPRS_ROWS_DEFAULT : rowsPerFrame;

	// which lanes carry data in the current lane count
	logic [15:0] laneUsed;
	genvar gi;
	generate
		for (gi = 0; gi < LPRS_LANES; gi++) begin : g_lane
			wire [3:0] laneNum = 4'(gi);
			assign laneUsed[gi] = (laneNum & (stride_reg - 4'h1)) == 4'h0;
		end
	endgenerate

	// slot pushed into the crossing fifo this cycle
	lprs_slot_t wData;
	wire inFrame = state_reg != LPRS_IDLE;
	wire inPixel = state_reg == LPRS_BURST;
	always_comb begin
		wData.wide = wide_reg;
		wData.ctrl = '0;
		wData.ctrl[LPRS_CTRL_PIXEL] = inPixel;
		wData.ctrl[LPRS_CTRL_ROW] = inFrame;
		wData.ctrl[LPRS_CTRL_FRAME] = inFrame;
		wData.ctrl[LPRS_CTRL_GAP] = state_reg == LPRS_GAP;
		for (int i = 0; i < LPRS_LANES; i++) begin
			wData.pix[i] = (inPixel & laneUsed[i] & ~laneOff_reg[i]) ? pixelWords[i] : '0;
		end
	end

	// burst, gap, row and frame sequencing; one slot per master clock while the fifo is not full
	always_comb begin
		state_next = state_reg;
		pixCnt_next = pixCnt_reg;
		burstCnt_next = burstCnt_reg;
		rowCnt_next = rowCnt_reg;
		stride_next = stride_reg;
		wide_next = wide_reg;
		rowLimit_next = rowLimit_reg;
		case (state_reg)
			LPRS_IDLE: begin
				if (frameRise) begin
					state_next = LPRS_BURST;
					pixCnt_next = '0;
					burstCnt_next = '0;
					rowCnt_next = '0;
					stride_next = strideSel;
					wide_next = twelveBitMode;
					rowLimit_next = rowSel;
				end
			end
			LPRS_BURST: begin
				if (wrEn) begin
					pixCnt_next = pixCnt_reg + 7'h01;
					if (burstEnd) begin
						state_next = LPRS_GAP;
					end
				end
			end
			LPRS_GAP: begin
				if (wrEn) begin
					state_next = LPRS_BURST;
					pixCnt_next = '0;
					burstCnt_next = burstCnt_reg + 3'h1;
					if (rowEnd) begin
						burstCnt_next = '0;
						rowCnt_next = rowCnt_reg + 16'h0001;
						if (frameEnd) begin
							state_next = LPRS_IDLE;
						end
					end
				end
			end
			default: state_next = LPRS_IDLE;
		endcase
	end

	// frame request pin synchroniser
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			reqMeta_reg <= 1'b0;
			reqSync_reg <= 1'b0;
			reqLast_reg <= 1'b0;
		end else begin
			reqMeta_reg <= frameRequest;
			reqSync_reg <= reqMeta_reg;
			reqLast_reg <= reqSync_reg;
		end
	end

	// sequencer registers
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_reg <= LPRS_IDLE;
			pixCnt_reg <= '0;
			burstCnt_reg <= '0;
			rowCnt_reg <= '0;
			stride_reg <= LPRS_STRIDE_16;
			wide_reg <= 1'b0;
			rowLimit_reg <= LPRS_ROWS_DEFAULT;
			laneOff_reg <= '0;
			busy_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			pixCnt_reg <= pixCnt_next;
			burstCnt_reg <= burstCnt_next;
			rowCnt_reg <= rowCnt_next;
			stride_reg <= stride_next;
			wide_reg <= wide_next;
			rowLimit_reg <= rowLimit_next;
			laneOff_reg <= laneDisable;
			busy_reg <= state_next != LPRS_IDLE; // flop copy of the frame-active state
		end
	end

	// fifo write side with gray pointer to the link domain
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wBin_reg <= '0;
			wGray_reg <= '0;
			rGrayMeta_reg <= '0;
			rGraySync_reg <= '0;
			full_reg <= 1'b0;
		end else begin
			wBin_reg <= wBinNext;
			wGray_reg <= wGrayNext;
			rGrayMeta_reg <= rGray_reg;
			rGraySync_reg <= rGrayMeta_reg;
			full_reg <= fullNext;
		end
	end

	// storage has no reset: contents only read behind the pointers
	always_ff @(posedge clock) begin
		if (wrEn) begin
			fifoMem[wBin_reg[AW-1:0]] <= wData;
		end
	end

	assign pixelIndex = pixCnt_reg;
	assign burstIndex = burstCnt_reg;
	assign rowIndex = rowCnt_reg;
	assign readoutBusy = busy_reg;
	assign slotStall = full_reg;
	assign lanePowerDown = laneOff_reg;

	// ---------------- serial link domain ----------------
	logic linkRstMeta_reg, linkRstn_reg;
	logic [AW:0] rBin_reg, wGrayMeta_reg, wGraySync_reg;
	lprs_slot_t cur_reg;
	logic [3:0] bitIdx_reg;
	logic [15:0] laneOut_reg;
	logic ctrlOut_reg, fwdClk_reg;

	wire empty = rGray_reg == wGraySync_reg;
	wire [3:0] wordBits = cur_reg.wide ? LPRS_BITS_12 : LPRS_BITS_10;
	wire lastBit = bitIdx_reg == wordBits - 4'h1;
	wire rdEn = lastBit & ~empty;
	wire [AW:0] rBinNext = rBin_reg + (AW+1)'(rdEn);

	// idle slot keeps the width of the last word when the fifo runs dry
	lprs_slot_t idleSlot;
	always_comb begin
		idleSlot = '0;
		idleSlot.wide = cur_reg.wide;
	end

	// link reset release synchroniser
	always_ff @(posedge serialClock or negedge rstn) begin
		if (!rstn) begin
			linkRstMeta_reg <= 1'b0;
			linkRstn_reg <= 1'b0;
		end else begin
			linkRstMeta_reg <= 1'b1;
			linkRstn_reg <= linkRstMeta_reg;
		end
	end

	// fifo read side and bit shifter
	always_ff @(posedge serialClock or negedge linkRstn_reg) begin
		if (!linkRstn_reg) begin
			rBin_reg <= '0;
			rGray_reg <= '0;
			wGrayMeta_reg <= '0;
			wGraySync_reg <= '0;
			cur_reg <= '0;
			bitIdx_reg <= '0;
		end else begin
			wGrayMeta_reg <= wGray_reg;
			wGraySync_reg <= wGrayMeta_reg;
			rBin_reg <= rBinNext;
			rGray_reg <= rBinNext ^ (rBinNext >> 1);
			bitIdx_reg <= lastBit ? 4'h0 : bitIdx_reg + 4'h1;
			if (lastBit) begin
				cur_reg <= empty ? idleSlot : fifoMem[rBin_reg[AW-1:0]];
			end
		end
	end

	// lane bits, lsb first, with the forwarded clock high on bit zero
	always_ff @(posedge serialClock or negedge linkRstn_reg) begin
		if (!linkRstn_reg) begin
			laneOut_reg <= '0;
			ctrlOut_reg <= 1'b0;
			fwdClk_reg <= 1'b0;
		end else begin
			for (int i = 0; i < LPRS_LANES; i++) begin
				laneOut_reg[i] <= cur_reg.pix[i][bitIdx_reg];
			end
			ctrlOut_reg <= cur_reg.ctrl[bitIdx_reg];
			fwdClk_reg <= ~bitIdx_reg[0];
		end
	end

	assign dataLanes = laneOut_reg;
	assign controlLane = ctrlOut_reg;
	assign lvdsForwardedClock = fwdClk_reg;

	// ---------------- checks ----------------
	property p_burst_to_gap;
		@(posedge clock) disable iff (!rstn)
		state_reg == LPRS_BURST && burstEnd && wrEn |=> state_reg == LPRS_GAP;
	endproperty
	a_burst_to_gap: assert property (p_burst_to_gap) else $error("burst did not end after 128 pixels");

	property p_gap_one_slot;
		@(posedge clock) disable iff (!rstn)
		state_reg == LPRS_GAP && wrEn |=> state_reg != LPRS_GAP && pixCnt_reg == 7'h00;
	endproperty
	a_gap_one_slot: assert property (p_gap_one_slot) else $error("gap longer than one pixel");

	property p_pixel_step;
		@(posedge clock) disable iff (!rstn)
		state_reg == LPRS_BURST && !burstEnd && wrEn |=> pixCnt_reg == $past(pixCnt_reg) + 7'h01;
	endproperty
	a_pixel_step: assert property (p_pixel_step) else $error("pixel took other than one clock");

	property p_row_bursts;
		@(posedge clock) disable iff (!rstn)
		state_reg == LPRS_GAP && wrEn && !rowEnd |=> burstCnt_reg == $past(burstCnt_reg) + 3'h1
			&& rowCnt_reg == $past(rowCnt_reg);
	endproperty
	a_row_bursts: assert property (p_row_bursts) else $error("row ended before all bursts");

	property p_twelve_four;
		@(posedge clock) disable iff (!rstn)
		state_reg == LPRS_IDLE && frameRise && twelveBitMode && laneSelect != LPRS_SEL_2
			|=> stride_reg == LPRS_STRIDE_4 && wide_reg;
	endproperty
	a_twelve_four: assert property (p_twelve_four) else $error("12-bit mode not on 4 lanes");

	property p_frame_end;
		@(posedge clock) disable iff (!rstn)
		state_reg == LPRS_GAP && wrEn && rowEnd && frameEnd |=> state_reg == LPRS_IDLE;
	endproperty
	a_frame_end: assert property (p_frame_end) else $error("frame length differs from row setting");

	property p_lane_mask;
		@(posedge clock) disable iff (!rstn)
		(stride_reg == LPRS_STRIDE_8 |-> laneUsed == LPRS_LANES_8_MASK)
			and (stride_reg == LPRS_STRIDE_4 |-> laneUsed == LPRS_LANES_4_MASK)
			and (stride_reg == LPRS_STRIDE_2 |-> laneUsed == LPRS_LANES_2_MASK);
	endproperty
	a_lane_mask: assert property (p_lane_mask) else $error("wrong lanes in use");

	property p_fwd_clock;
		@(posedge serialClock) disable iff (!linkRstn_reg)
		bitIdx_reg == 4'h0 ##1 bitIdx_reg == 4'h1 |-> fwdClk_reg ##1 !fwdClk_reg;
	endproperty
	a_fwd_clock: assert property (p_fwd_clock) else $error("bit zero not in clock high phase");

	property p_lsb_first;
		@(posedge serialClock) disable iff (!linkRstn_reg)
		bitIdx_reg == 4'h0 |=> laneOut_reg[0] == $past(cur_reg.pix[0][0]);
	endproperty
	a_lsb_first: assert property (p_lsb_first) else $error("first serial bit is not the lsb");

	property p_word_width;
		@(posedge serialClock) disable iff (!linkRstn_reg)
		bitIdx_reg == 4'h9 && !cur_reg.wide |=> bitIdx_reg == 4'h0;
	endproperty
	a_word_width: assert property (p_word_width) else $error("10-bit word not ten bits long");
endmodule
`default_nettype wire

// *** core/lprs_pkg.sv ***
// shared constants and types of the pixel read-out serializer
`default_nettype none
package lprs_pkg;
	localparam int LPRS_LANES = 16;
	localparam int LPRS_WORD_MAX = 12;
	localparam logic [3:0] LPRS_BITS_10 = 4'hA;
	localparam logic [3:0] LPRS_BITS_12 = 4'hC;
	// highest master clock per width, MHz; serial bit = master period / width
	localparam int LPRS_MAX_CLK_10BIT_MHZ = 48;
	localparam int LPRS_MAX_CLK_12BIT_MHZ = 40;
	localparam logic [6:0] LPRS_BURST_LAST = 7'h7F;
	localparam logic [15:0] LPRS_ROWS_DEFAULT = 16'h0800;
	// lane-count selector codes
	localparam logic [1:0] LPRS_SEL_16 = 2'h0;
	localparam logic [1:0] LPRS_SEL_8 = 2'h1;
	localparam logic [1:0] LPRS_SEL_4 = 2'h2;
	localparam logic [1:0] LPRS_SEL_2 = 2'h3;
	// bursts per row (also lane stride) for each lane count
	localparam logic [3:0] LPRS_STRIDE_16 = 4'h1;
	localparam logic [3:0] LPRS_STRIDE_8 = 4'h2;
	localparam logic [3:0] LPRS_STRIDE_4 = 4'h4;
	localparam logic [3:0] LPRS_STRIDE_2 = 4'h8;
	// control lane word fields
	localparam int LPRS_CTRL_PIXEL = 0;
	localparam int LPRS_CTRL_ROW = 1;
	localparam int LPRS_CTRL_FRAME = 2;
	localparam int LPRS_CTRL_GAP = 3;
	localparam int LPRS_FIFO_DEPTH = 4;
	localparam logic [15:0] LPRS_LANES_8_MASK = 16'h5555;
	localparam logic [15:0] LPRS_LANES_4_MASK = 16'h1111;
	localparam logic [15:0] LPRS_LANES_2_MASK = 16'h0101;

	typedef enum logic [1:0] {
		LPRS_IDLE = 2'b00,
		LPRS_BURST = 2'b01,
		LPRS_GAP = 2'b11
	} lprs_state_t;

	typedef logic [LPRS_WORD_MAX-1:0] lprs_word_t;

	// one master-clock slot: all lane words plus the control word
	typedef struct packed {
		logic wide;
		lprs_word_t ctrl;
		lprs_word_t [LPRS_LANES-1:0] pix;
	} lprs_slot_t;
endpackage
`default_nettype wire

// *** dv/lprs_receiver.sv ***
// receiver model: deserializes lane one and the control lane, counts words
`default_nettype none
module lprs_receiver
	import lprs_pkg::*;
(
	input wire logic serialClock,
	input wire logic rstn,
	input wire logic realign,
	input wire logic twelveBitMode,
	input wire logic [15:0] dataLanes,
	input wire logic controlLane,
	input wire logic lvdsForwardedClock,
	output logic [15:0] validCount,
	output logic [7:0] gapCount,
	output lprs_word_t lastWord,
	output logic [15:0] lanesSeen,
	output logic clockFault
);
	timeunit 1ns;
	timeprecision 100ps;
	logic aligned;
	logic [3:0] bitIdx;
	lprs_word_t wordAcc;
	lprs_word_t ctrlAcc;
	// index of the last bit and the words including the bit on the wire now
	wire logic [3:0] lastBit = twelveBitMode ? 4'hB : 4'h9;
	wire lprs_word_t wordNow = wordAcc | (lprs_word_t'(dataLanes[0]) << bitIdx);
	wire lprs_word_t ctrlNow = ctrlAcc | (lprs_word_t'(controlLane) << bitIdx);
	// first control one marks bit zero of the first frame word
	always_ff @(posedge serialClock) begin
		if (!rstn || realign) begin
			aligned <= 1'b0;
			bitIdx <= 4'h0;
			wordAcc <= '0;
			ctrlAcc <= '0;
			validCount <= 16'h0000;
			gapCount <= 8'h00;
			lastWord <= '0;
			lanesSeen <= 16'h0000;
			clockFault <= 1'b0;
		end else if (!aligned) begin
			if (controlLane) begin
				aligned <= 1'b1;
				bitIdx <= 4'h1;
				wordAcc <= wordNow;
				ctrlAcc <= ctrlNow;
				lanesSeen <= lanesSeen | dataLanes;
				clockFault <= clockFault | !lvdsForwardedClock;
			end
		end else begin
			lanesSeen <= lanesSeen | dataLanes;
			clockFault <= clockFault | (lvdsForwardedClock == bitIdx[0]);
			if (bitIdx == lastBit) begin
				bitIdx <= 4'h0;
				wordAcc <= '0;
				ctrlAcc <= '0;
				if (ctrlNow[LPRS_CTRL_PIXEL]) begin
					validCount <= validCount + 16'h0001;
					lastWord <= wordNow;
				end
				if (ctrlNow[LPRS_CTRL_GAP]) begin
					gapCount <= gapCount + 8'h01;
				end
			end else begin
				bitIdx <= bitIdx + 4'h1;
				wordAcc <= wordNow;
				ctrlAcc <= ctrlNow;
			end
		end
	end
endmodule
`default_nettype wire

// *** dv/lvds_pixel_readout_serializer_test.sv ***
// frame-level testbench of the pixel read-out serializer
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
	$display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module lvds_pixel_readout_serializer_test
	import lprs_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clock = 1'b0;
	logic serialClock = 1'b0;
	logic rstn, frameRequest, twelveBitMode, realign;
	logic [1:0] laneSelect;
	logic [15:0] rowsPerFrame, laneDisable;
	lprs_word_t [LPRS_LANES-1:0] pixelWords;
	logic [2:0] burstIndex;
	logic readoutBusy, slotStall, controlLane, lvdsForwardedClock, clockFault;
	logic [15:0] lanePowerDown, dataLanes, validCount, lanesSeen;
	logic [7:0] gapCount;
	lprs_word_t lastWord;
	logic [2:0] topBurst;
	logic [6:0] pixelIndex, topPixel;
	logic [15:0] rowIndex;
	int frameSlots;
	int error_cnt = 0;
	int n_compared = 0;
	// master clock and link clock of unrelated phase
	always #5 clock = ~clock;
	always begin
		#7 serialClock = 1'b1;
		#15 serialClock = 1'b0;
		#8;
	end
	lvds_pixel_readout_serializer #(.FIFO_DEPTH(4)) lvds_pixel_readout_serializer_inst (.clock(clock),
		.rstn(rstn), .serialClock(serialClock), .frameRequest(frameRequest), .laneSelect(laneSelect),
		.twelveBitMode(twelveBitMode), .rowsPerFrame(rowsPerFrame), .laneDisable(laneDisable),
		.pixelWords(pixelWords), .pixelIndex(pixelIndex), .burstIndex(burstIndex), .rowIndex(rowIndex),
		.readoutBusy(readoutBusy), .slotStall(slotStall), .lanePowerDown(lanePowerDown),
		.dataLanes(dataLanes), .controlLane(controlLane), .lvdsForwardedClock(lvdsForwardedClock));
	lprs_receiver lprs_receiver_inst (.serialClock(serialClock), .rstn(rstn), .realign(realign),
		.twelveBitMode(twelveBitMode), .dataLanes(dataLanes), .controlLane(controlLane),
		.lvdsForwardedClock(lvdsForwardedClock), .validCount(validCount), .gapCount(gapCount),
		.lastWord(lastWord), .lanesSeen(lanesSeen), .clockFault(clockFault));
	task automatic end_of_test();
		$display("compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// one frame: request, count consumed slots, let the link drain
	task automatic run_frame(input logic [1:0] sel, input logic twelve, input logic [15:0] rows,
		input logic [15:0] off);
		int guard;
		@(posedge clock);
		laneSelect <= sel;
		twelveBitMode <= twelve;
		rowsPerFrame <= rows;
		laneDisable <= off;
		realign <= 1'b1;
		repeat (8) @(posedge clock);
		realign <= 1'b0;
		frameRequest <= 1'b1;
		guard = 0;
		while (readoutBusy !== 1'b1 && guard < 10) begin
			@(negedge clock);
			guard++;
		end
		// count consumed slots at mid-cycle, from the first busy cycle on
		frameSlots = 0;
		topBurst = 3'h0;
		topPixel = 7'h00;
		while (readoutBusy === 1'b1 && guard < 60000) begin
			frameSlots += (slotStall === 1'b0) ? 1 : 0;
			if (burstIndex > topBurst) topBurst = burstIndex;
			if (pixelIndex > topPixel) topPixel = pixelIndex;
			@(negedge clock);
			guard++;
		end
		@(posedge clock);
		frameRequest <= 1'b0;
		repeat (400) @(posedge clock);
		`CHK(lastWord, twelve ? 12'hC35 : 12'h035)
		`CHK(clockFault, 1'b0)
		`CHK(lanePowerDown, off)
		`CHK(topPixel, LPRS_BURST_LAST)
		`CHK(rowIndex, rows)
	endtask
	task automatic check_sixteen_lanes();
		run_frame(LPRS_SEL_16, 1'b0, 16'h0002, 16'h0000);
		`CHK(validCount, 16'h0100)
		`CHK(gapCount, 8'h02)
		`CHK(frameSlots, 258)
		`CHK(lanesSeen, 16'hFFFF)
		`CHK(topBurst, 3'h0)
	endtask
	task automatic check_eight_lanes();
		run_frame(LPRS_SEL_8, 1'b0, 16'h0001, 16'h0004);
		`CHK(validCount, 16'h0100)
		`CHK(gapCount, 8'h02)
		`CHK(frameSlots, 258)
		`CHK(lanesSeen, 16'h5551)
		`CHK(topBurst, 3'h1)
	endtask
	task automatic check_four_lanes();
		run_frame(LPRS_SEL_4, 1'b0, 16'h0001, 16'h0000);
		`CHK(validCount, 16'h0200)
		`CHK(gapCount, 8'h04)
		`CHK(frameSlots, 516)
		`CHK(lanesSeen, 16'h1111)
		`CHK(topBurst, 3'h3)
	endtask
	task automatic check_twelve_default();
		run_frame(LPRS_SEL_16, 1'b1, 16'h0001, 16'h0000);
		`CHK(validCount, 16'h0200)
		`CHK(gapCount, 8'h04)
		`CHK(frameSlots, 516)
		`CHK(lanesSeen, 16'h1111)
		`CHK(topBurst, 3'h3)
	endtask
	task automatic check_twelve_two_lanes();
		run_frame(LPRS_SEL_2, 1'b1, 16'h0001, 16'h0000);
		`CHK(validCount, 16'h0400)
		`CHK(gapCount, 8'h08)
		`CHK(frameSlots, 1032)
		`CHK(lanesSeen, 16'h0101)
		`CHK(topBurst, 3'h7)
	endtask
	// main sequence
	initial begin
		rstn <= 1'b0;
		frameRequest <= 1'b0;
		realign <= 1'b0;
		laneSelect <= LPRS_SEL_16;
		twelveBitMode <= 1'b0;
		rowsPerFrame <= 16'h0001;
		laneDisable <= 16'h0000;
		pixelWords <= {LPRS_LANES{12'hC35}};
		repeat (3) @(posedge clock);
		rstn <= 1'b1;
		repeat (10) @(posedge clock);
		check_sixteen_lanes();
		check_eight_lanes();
		check_four_lanes();
		check_twelve_default();
		check_twelve_two_lanes();
		end_of_test();
	end
	// watchdog against a hung frame
	initial begin
		repeat (100000) @(posedge clock);
		error_cnt++;
		end_of_test();
	end
endmodule
`undef CHK
`default_nettype wire
